// [logic/svtd_top.sv]
// supply voltage threshold detector: control register, flag, settle gating
//
// Contract
// - enable bit switches detector on and off
// - each enable waits out a settling interval
// - bit 5 read-only stable flag, set when settled
// - crossings ignored until stable flag is set
// - direction 0 flags supply at or below
// - direction 1 flags supply at or above
// - bits 3-0 pick threshold, 1111 reserved
// - crossing in chosen direction sets event flag
// - event flag sits at flag register bit 2
// - reset returns control register, detector off
`timescale 1ns/1ps
module svtd_top import svtd_pkg::*; #(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic supplyBelow,
	input wire logic supplyAbove,
	output logic detectorPowerEnable,
	output logic [3:0] thresholdLevelField,
	output logic externalTripSelect,
	output logic thresholdCrossEventFlag
);
	initial begin
		if (SETTLE < 1) begin
			$error("settle count must be at least one");
		end
	end

	svtd_settle_if settle ();

	logic dir_q;
	logic en_q;
	logic [3:0] level_q;
	logic flag_q;
	logic [7:0] rdata_q;
	logic stable;
	logic hit;
	logic wrCtrl;
	logic wrFlag;
	logic [7:0] ctrlView;

	////////////////////////////////////////////////////////////////////////
	svtd_settle_timer #(
		.SETTLE(SETTLE)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.settle(settle)
	);

	assign settle.enable = en_q;
	assign stable = settle.stable;
	assign wrCtrl = regWrite && (regAddr == CTRL_OFFSET);
	assign wrFlag = regWrite && (regAddr == FLAG_OFFSET);

	////////////////////////////////////////////////////////////////////////
	// control register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dir_q <= CTRL_RESET[DIR_BIT];
			en_q <= CTRL_RESET[ENABLE_BIT];
			level_q <= CTRL_RESET[LEVEL_LSB +: LEVEL_W];
		end else if (wrCtrl) begin
			dir_q <= regWdata[DIR_BIT];
			en_q <= regWdata[ENABLE_BIT];
			level_q <= regWdata[LEVEL_LSB +: LEVEL_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing detection, gated by the stable flag
	always_comb begin
		if (dir_q) begin
			hit = supplyAbove;
		end else begin
			hit = supplyBelow;
		end
		hit = hit && en_q && stable;
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else if (hit) begin
			flag_q <= 1'b1;
		end else if (wrFlag) begin
			flag_q <= regWdata[CROSS_FLAG_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe
	always_comb begin
		ctrlView = 8'h00;
		ctrlView[DIR_BIT] = dir_q;
		ctrlView[STABLE_BIT] = stable;
		ctrlView[ENABLE_BIT] = en_q;
		ctrlView[LEVEL_LSB +: LEVEL_W] = level_q;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				CTRL_OFFSET: begin
					rdata_q <= ctrlView;
				end
				FLAG_OFFSET: begin
					rdata_q <= 8'h00;
					rdata_q[CROSS_FLAG_BIT] <= flag_q;
				end
				default: begin
					rdata_q <= 8'h00;
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs to the analog side
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			detectorPowerEnable <= 1'b0;
			thresholdLevelField <= CTRL_RESET[LEVEL_LSB +: LEVEL_W];
			externalTripSelect <= 1'b0;
		end else begin
			detectorPowerEnable <= en_q;
			thresholdLevelField <= level_q;
			externalTripSelect <= (level_q == LEVEL_RESERVED);
		end
	end

	assign regRdata = rdata_q;
	assign thresholdCrossEventFlag = flag_q;
endmodule

// [logic/svtd_pkg.sv]
// package: register map, field positions, reset values, timing constants
package svtd_pkg;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] FLAG_OFFSET = 8'h01;
	localparam int DIR_BIT = 7;
	localparam int STABLE_BIT = 5;
	localparam int ENABLE_BIT = 4;
	localparam int LEVEL_LSB = 0;
	localparam int LEVEL_W = 4;
	localparam int CROSS_FLAG_BIT = 2;
	localparam logic [3:0] LEVEL_RESERVED = 4'hf;
	localparam logic [7:0] CTRL_RESET = 8'h05;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam int SETTLE_TIME_NS = 20000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_CYCLES =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SVTD_OFF = 2'b00,
		SVTD_SETTLE = 2'b01,
		SVTD_STABLE = 2'b10
	} svtd_state_t;
endpackage

// [logic/svtd_settle_if.sv]
// interface: enable request and settled indication between top and timer
`timescale 1ns/1ps
interface svtd_settle_if;
	logic enable;
	logic stable;
	modport top (output enable, input stable);
	modport timer (input enable, output stable);
endinterface

// [logic/svtd_settle_timer.sv]
// settling timer: counts the stabilisation interval after each enable
`timescale 1ns/1ps
module svtd_settle_timer import svtd_pkg::*; #(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	svtd_settle_if.timer settle
);
	initial begin
		if (SETTLE < 1) begin
			$error("settle count must be at least one");
		end
	end

	localparam int CW = $clog2(SETTLE + 1);
	localparam logic [CW-1:0] LAST = CW'(SETTLE - 1);

	svtd_state_t state_q;
	logic [CW-1:0] count_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= SVTD_OFF;
			count_q <= '0;
		end else if (!settle.enable) begin
			state_q <= SVTD_OFF;
			count_q <= '0;
		end else begin
			case (state_q)
				SVTD_OFF: begin
					state_q <= SVTD_SETTLE;
					count_q <= '0;
				end
				SVTD_SETTLE: begin
					if (count_q == LAST) begin
						state_q <= SVTD_STABLE;
					end else begin
						count_q <= count_q + 1'b1;
					end
				end
				SVTD_STABLE: begin
					state_q <= SVTD_STABLE;
				end
				default: begin
					state_q <= SVTD_OFF;
				end
			endcase
		end
	end

	assign settle.stable = (state_q == SVTD_STABLE);
endmodule

// [dv/svtd_checker.sv]
// checker: port-level properties of the threshold detector
`timescale 1ns/1ps
module svtd_checker import svtd_pkg::*; #(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdata,
	input wire logic supplyBelow,
	input wire logic supplyAbove,
	input wire logic detectorPowerEnable,
	input wire logic [3:0] thresholdLevelField,
	input wire logic externalTripSelect,
	input wire logic thresholdCrossEventFlag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic flg = thresholdCrossEventFlag;
	wire logic wCtl = regWrite && regAddr == CTRL_OFFSET;
	wire logic wOn = wCtl && regWdata[ENABLE_BIT];
	wire logic wOff = wCtl && !regWdata[ENABLE_BIT];
	logic [11:0] onCnt;
	// cycles the detector has been powered
	always_ff @(posedge core_clk)
		onCnt <= detectorPowerEnable ? onCnt + 12'h001 : 12'h000;
	a_reset_off: assert property ($past(!rst_n) |->
		!detectorPowerEnable && thresholdLevelField == 4'h5)
		else $error("not off after reset");
	a_pwr_on: assert property ($rose(detectorPowerEnable) |->
		$past(wOn) || $past(wOn, 2))
		else $error("power rose without enable write");
	a_pwr_off: assert property ($fell(detectorPowerEnable) |->
		$past(wOff) || $past(wOff, 2))
		else $error("power fell without disable write");
	a_level_track: assert property ($past(wCtl) |=>
		thresholdLevelField == $past(regWdata[3:0], 2))
		else $error("level field wrong");
	a_trip_sel: assert property (externalTripSelect ==
		(thresholdLevelField == LEVEL_RESERVED))
		else $error("trip select wrong");
	a_flag_settled: assert property ($rose(flg) && !$past(regWrite)
		|-> onCnt >= SETTLE - 1)
		else $error("flag before settling");
	a_flag_sticky: assert property ($fell(flg) |-> $past(regWrite &&
		regAddr == FLAG_OFFSET && !regWdata[CROSS_FLAG_BIT]))
		else $error("flag dropped alone");
	a_flag_cause: assert property ($rose(flg) |->
		$past(supplyBelow || supplyAbove || regWrite))
		else $error("flag without cause");
	cover property ($rose(flg));
	cover property ($rose(detectorPowerEnable));
	cover property (regRead && regAddr == FLAG_OFFSET);
endmodule
bind svtd_top svtd_checker #(.SETTLE(SETTLE)) u_chk (.*);

// [dv/svtd_tb_top.sv]
// bench: register traffic and comparator stimulus for the detector
`timescale 1ns/1ps
module svtd_tb_top import svtd_pkg::*;;
	logic core_clk = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0;
	logic supplyBelow = 1'h0, supplyAbove = 1'h0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
	logic detectorPowerEnable, externalTripSelect, thresholdCrossEventFlag;
	logic [3:0] thresholdLevelField;
	int fail_count = 0, samples_checked = 0;
	logic [15:0] seed = 16'h2df5;
	svtd_top #(.SETTLE(4)) DUT (.*);
	always #10 core_clk = ~core_clk;
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] ctl(logic d, s, e, logic [3:0] l);
		return {d, 1'h0, s, e, l};
	endfunction
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWrite <= 1'h0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge core_clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'h0;
		#1;
		samples_checked++;
		if (regRdata !== e) begin
			fail_count++;
			$display("MISMATCH %0t addr %h got %h", $time, a, regRdata);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		logic d;
		logic [3:0] l;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'h1;
		wr(8'h07, 8'hff);
		rd(CTRL_OFFSET, 8'h05);
		rd(8'h07, 8'h00);
		wr(CTRL_OFFSET, 8'hff);
		rd(CTRL_OFFSET, 8'h9f);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			d = i[0];
			l = i == 0 ? 4'hf : seed[3:0];
			wr(CTRL_OFFSET, ctl(d, 1'h0, 1'h0, l));
			wr(FLAG_OFFSET, 8'h00);
			{supplyAbove, supplyBelow} <= 2'h3;
			wr(CTRL_OFFSET, ctl(d, seed[9], 1'h1, l));
			rd(CTRL_OFFSET, ctl(d, 1'h0, 1'h1, l));
			rd(FLAG_OFFSET, 8'h00);
			{supplyAbove, supplyBelow} <= d ? 2'h1 : 2'h2;
			repeat (8) @(posedge core_clk);
			rd(CTRL_OFFSET, ctl(d, 1'h1, 1'h1, l));
			samples_checked++;
			if ({detectorPowerEnable, thresholdLevelField} !== {1'h1, l}) begin
				fail_count++;
				$display("MISMATCH %0t analog outputs wrong", $time);
			end
			samples_checked++;
			if (externalTripSelect !== (l == 4'hf)) begin
				fail_count++;
				$display("MISMATCH %0t trip select wrong", $time);
			end
			samples_checked++;
			if (thresholdCrossEventFlag !== 1'h0) begin
				fail_count++;
				$display("MISMATCH %0t event flag set early", $time);
			end
			rd(FLAG_OFFSET, 8'h00);
			{supplyAbove, supplyBelow} <= d ? 2'h2 : 2'h1;
			rd(FLAG_OFFSET, 8'h04);
			wr(CTRL_OFFSET, ctl(d, 1'h0, 1'h0, l));
			wr(FLAG_OFFSET, 8'h00);
			rd(FLAG_OFFSET, 8'h00);
			rd(CTRL_OFFSET, ctl(d, 1'h0, 1'h0, l));
			{supplyAbove, supplyBelow} <= 2'h0;
		end
		results();
	end
endmodule
